// >>> hw/edge_counter_pkg.sv
/*
  Shared constants, register map and types for the gated edge and period
  counter. Assumes a 32-bit classic Wishbone register bus.
*/
package edge_counter_pkg;

  localparam int CNT_W = 32;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ARM    = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;
  localparam logic [7:0] REG_SAVE   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W   = 3;
  localparam int CTRL_SRC_FALL = 4;
  localparam int CTRL_GATE_POL = 5;
  localparam int CTRL_DIR_LSB  = 6;
  localparam int CTRL_DIR_W    = 2;
  localparam int CTRL_CUMUL    = 8;
  localparam int CTRL_BUFFERED = 9;
  localparam int CTRL_W        = 10;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // Status register field positions.
  localparam int STAT_ARMED = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_SAVED = 2;
  localparam int STAT_OVERRUN = 3;

  // Arm register: writing this bit arms the counter, writing stop disarms.
  localparam int ARM_BIT  = 0;
  localparam int STOP_BIT = 1;

  typedef enum logic [2:0] {
    MODE_EDGE   = 3'b000,
    MODE_PULSE  = 3'b001,
    MODE_PERIOD = 3'b010,
    MODE_SEMI   = 3'b011
  } mode_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b00,
    DIR_DOWN = 2'b01,
    DIR_EXT  = 2'b10
  } dir_t;

  typedef struct packed {
    logic  buffered;
    logic  cumulative;
    dir_t  dir;
    logic  gate_pol;
    logic  src_fall;
    logic  spare;
    mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic             valid;
    logic [CNT_W-1:0] data;
  } capture_t;

endpackage

// >>> hw/pin_sync_edge.sv
/*
  Two-flop synchroniser with rise and fall detection on the synchronised
  level. Assumes the input is asynchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // The first flop feeds only the second flop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule
`default_nettype wire

// >>> hw/capture_hold.sv
/*
  One-entry capture holder for the DMA stream: holds a value stable from
  load until the consumer accepts it or a new load replaces it. Assumes same-clock consumer.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_hold
  import edge_counter_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_data,
  input  wire logic         accept,
  output logic              valid,
  output logic [W-1:0]      data,
  output logic              overrun
);
  logic         valid_q;
  logic [W-1:0] data_q;

  // A new capture replaces an unaccepted one; the loss is flagged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end else if (load) begin
      valid_q <= 1'b1;
      data_q  <= load_data;
    end else if (accept) begin
      valid_q <= 1'b0;
    end
  end

  assign valid   = valid_q;
  assign data    = data_q;
  assign overrun = load & valid_q & ~accept;
endmodule
`default_nettype wire

// >>> hw/gated_edge_period_counter.sv
/*
  Gated edge and period counter with a classic Wishbone register slave and
  a valid/accept capture stream toward a DMA controller. Assumes Source,
  Gate and direction inputs are asynchronous and slow against SYS_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module gated_edge_period_counter
  import edge_counter_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RST_N,
  input  wire logic [7:0]       WB_ADR_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic      [31:0]      WB_DAT_O,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic             WB_WE_I,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  output logic                  WB_ACK_O,
  output logic                  WB_ERR_O,
  input  wire logic             SOURCE,
  input  wire logic             GATE,
  input  wire logic             DIR_SEL,
  output logic                  DMA_VALID,
  output logic      [WIDTH-1:0] DMA_DATA,
  input  wire logic             DMA_ACCEPT
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic src_lvl, src_rise, src_fall;
  logic gate_lvl, gate_rise, gate_fall;
  logic dir_lvl;

  pin_sync_edge u_src (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .pin   (SOURCE),
    .level (src_lvl),
    .rise  (src_rise),
    .fall  (src_fall)
  );

  pin_sync_edge u_gate (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .pin   (GATE),
    .level (gate_lvl),
    .rise  (gate_rise),
    .fall  (gate_fall)
  );

  pin_sync_edge u_dir (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .pin   (DIR_SEL),
    .level (dir_lvl),
    .rise  (),
    .fall  ()
  );

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  ctrl_t            ctrl_q;
  logic             armed_q;
  logic             done_q;
  logic             saved_q;
  logic             started_q;
  logic             ack_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] save_q;

  logic wb_req;
  logic wr_ctrl, wr_arm, arm_go, stop_go;
  logic src_edge, gate_act_edge, gate_trail_edge, gate_any_edge;
  logic gate_active, paused, count_en, capture, clear_after;
  logic [WIDTH-1:0] count_step;
  logic overrun, overrun_q;
  logic [WIDTH-1:0] cap_value;
  logic [31:0]      status_word;

  // A held request is answered every other cycle; the cycle after any answer is idle.
  assign wb_req  = WB_CYC_I & WB_STB_I & ~ack_q & ~WB_ERR_O;
  assign wr_ctrl = wb_req & WB_WE_I & WB_SEL_I[0]
                 & (WB_ADR_I == REG_CTRL);
  assign wr_arm  = wb_req & WB_WE_I & WB_SEL_I[0]
                 & (WB_ADR_I == REG_ARM);
  assign arm_go  = wr_arm & WB_DAT_I[ARM_BIT];
  assign stop_go = wr_arm & WB_DAT_I[STOP_BIT];

  // ****************************************************************
  // Edge selection
  // ****************************************************************
  assign src_edge = ctrl_q.src_fall ? src_fall : src_rise;
  // Gate polarity bit: 0 means high level is active (or pause high).
  assign gate_active     = gate_lvl ^ ctrl_q.gate_pol;
  assign gate_act_edge   = ctrl_q.gate_pol ? gate_fall : gate_rise;
  assign gate_trail_edge = ctrl_q.gate_pol ? gate_rise : gate_fall;
  assign gate_any_edge   = gate_rise | gate_fall;

  // Gate serves as pause only in unbuffered edge counting.
  assign paused = (ctrl_q.mode == MODE_EDGE) & ~ctrl_q.buffered
                & gate_active;

  // ****************************************************************
  // Count enable and capture decisions
  // ****************************************************************
  always_comb begin
    count_en    = 1'b0;
    capture     = 1'b0;
    clear_after = 1'b0;
    if (armed_q && !done_q) begin
      unique case (ctrl_q.mode)
        MODE_EDGE: begin
          count_en = src_edge & ~paused;
          if (ctrl_q.buffered) begin
            capture     = gate_act_edge;
            clear_after = ~ctrl_q.cumulative;
          end
        end
        MODE_PULSE: begin
          // Count only inside a pulse whose leading edge was seen.
          count_en = src_edge & started_q & gate_active;
          capture  = started_q & gate_trail_edge;
          clear_after = 1'b1;
        end
        MODE_PERIOD: begin
          count_en    = src_edge & (ctrl_q.buffered | started_q);
          capture     = gate_act_edge & (ctrl_q.buffered | started_q);
          clear_after = 1'b1;
        end
        MODE_SEMI: begin
          if (ctrl_q.buffered) begin
            count_en    = src_edge;
            capture     = gate_any_edge;
            clear_after = 1'b1;
          end else begin
            // Single semi-period behaves as single pulse width.
            count_en    = src_edge & started_q & gate_active;
            capture     = started_q & gate_trail_edge;
            clear_after = 1'b1;
          end
        end
        default: begin
          count_en = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    count_step = count_q;
    unique case (ctrl_q.dir)
      DIR_UP:   count_step = count_q + WIDTH'(1);
      DIR_DOWN: count_step = count_q - WIDTH'(1);
      DIR_EXT:  count_step = dir_lvl ? count_q + WIDTH'(1)
                                     : count_q - WIDTH'(1);
      default:  count_step = count_q;
    endcase
  end

  // ****************************************************************
  // Control and arming
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl && !armed_q) begin
      // Reconfiguring a running measurement is refused.
      ctrl_q <= ctrl_t'(WB_DAT_I[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      armed_q <= 1'b0;
    end else if (arm_go) begin
      armed_q <= 1'b1;
    end else if (stop_go) begin
      armed_q <= 1'b0;
    end
  end

  // Single measurements freeze after their one capture.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else if (arm_go) begin
      done_q <= 1'b0;
    end else if (capture && !ctrl_q.buffered
                 && ctrl_q.mode != MODE_EDGE) begin
      done_q <= 1'b1;
    end
  end

  // Pulse modes start on entry to active; period on first active edge.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      started_q <= 1'b0;
    end else if (arm_go) begin
      started_q <= 1'b0;
    end else if (armed_q) begin
      if (ctrl_q.mode == MODE_PERIOD) begin
        if (gate_act_edge) begin
          started_q <= 1'b1;
        end
      end else if (gate_act_edge) begin
        started_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Counter and save register
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_q <= '0;
    end else if (arm_go) begin
      count_q <= '0;
    end else if (capture && clear_after) begin
      // A coincident Source edge belongs to the interval just captured.
      count_q <= '0;
    end else if (count_en) begin
      count_q <= count_step;
    end
  end

  assign cap_value = count_en ? count_step : count_q;

  // Capture takes the count including a coincident Source edge.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      save_q  <= '0;
      saved_q <= 1'b0;
    end else begin
      if (capture) begin
        save_q  <= cap_value;
        saved_q <= 1'b1;
      end else if (arm_go) begin
        saved_q <= 1'b0;
      end
    end
  end

  capture_hold #(
    .W (WIDTH)
  ) u_hold (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .load      (capture & ctrl_q.buffered),
    .load_data (cap_value),
    .accept    (DMA_ACCEPT),
    .valid     (DMA_VALID),
    .data      (DMA_DATA),
    .overrun   (overrun)
  );

  // ****************************************************************
  // Status and lost captures
  // ****************************************************************
  // A lost capture stays flagged until the next arm, so software can
  // tell that the stream dropped a value it never saw.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      overrun_q <= 1'b0;
    end else if (overrun) begin
      overrun_q <= 1'b1;
    end else if (arm_go) begin
      overrun_q <= 1'b0;
    end
  end

  always_comb begin
    status_word               = '0;
    status_word[STAT_ARMED]   = armed_q;
    status_word[STAT_DONE]    = done_q;
    status_word[STAT_SAVED]   = saved_q;
    status_word[STAT_OVERRUN] = overrun_q;
  end

  // ****************************************************************
  // Wishbone slave: one wait-free answer the cycle after the request
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q    <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      ack_q    <= 1'b0;
      WB_ERR_O <= 1'b0;
      if (wb_req) begin
        ack_q    <= 1'b1;
        WB_DAT_O <= '0;
        unique case (WB_ADR_I)
          REG_CTRL:   WB_DAT_O <= 32'(ctrl_q);
          REG_ARM:    WB_DAT_O <= '0;
          REG_COUNT:  WB_DAT_O <= 32'(count_q);
          REG_SAVE:   WB_DAT_O <= 32'(save_q);
          REG_STATUS: WB_DAT_O <= status_word;
          default: begin
            ack_q    <= 1'b0;
            WB_ERR_O <= 1'b1;
          end
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_q;

endmodule
`default_nettype wire

// >>> verification/gated_edge_period_counter_chk.sv
/* Port-level checks for the gated edge and period counter.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module gated_edge_period_counter_chk
  import edge_counter_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic             SYS_CLK,
  input wire logic             RST_N,
  input wire logic [7:0]       WB_ADR_I,
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_ACK_O,
  input wire logic             WB_ERR_O,
  input wire logic             GATE,
  input wire logic             DMA_VALID,
  input wire logic [WIDTH-1:0] DMA_DATA,
  input wire logic             DMA_ACCEPT
);
  // ********
  // Helpers and properties
  // ********
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Cycles since Gate last moved; it saturates so a quiet Gate never wraps.
  logic       gate_q;
  logic [3:0] age_q;
  logic       mapped;
  assign mapped = WB_ADR_I inside {REG_CTRL, REG_ARM, REG_COUNT,
                                   REG_SAVE, REG_STATUS};
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_q <= 1'b0;
      age_q  <= 4'hf;
    end else begin
      gate_q <= GATE;
      age_q  <= (GATE != gate_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
    end
  end
  sequence take_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  sequence answer_s;
    (WB_ACK_O || WB_ERR_O) ##1 !(WB_ACK_O || WB_ERR_O);
  endsequence
  bus_answer_a: assert property (take_s |=> answer_s)
    else $error("bus answer late or held too long");
  answer_kind_a: assert property ((WB_ACK_O || WB_ERR_O) |->
    $past(WB_CYC_I) && $past(WB_STB_I) && (WB_ERR_O == !$past(mapped)))
    else $error("bus answer without request or of wrong kind");
  answer_excl_a: assert property (!(WB_ACK_O && WB_ERR_O))
    else $error("ack and err together");
  dma_hold_a: assert property (DMA_VALID && !DMA_ACCEPT |=> DMA_VALID)
    else $error("capture dropped before accept");
  dma_stable_a: assert property (
    DMA_VALID && !DMA_ACCEPT && age_q == 4'hf |=> $stable(DMA_DATA))
    else $error("capture data moved while waiting");
  dma_drop_a: assert property ($fell(DMA_VALID) |-> $past(DMA_ACCEPT))
    else $error("capture withdrawn without accept");
  capture_cause_a: assert property ($rose(DMA_VALID) |-> age_q < 4'ha)
    else $error("capture with no recent gate edge");
  reset_quiet_a: assert property ($rose(RST_N) |->
    !WB_ACK_O && !WB_ERR_O && !DMA_VALID)
    else $error("outputs busy right after reset");
endmodule
`default_nettype wire

// >>> verification/sig_src.sv
/* Far-side model of the Source, Gate and direction pins.
   Assumes the bench calls its tasks from a single process. */
`timescale 1ns/1ps
`default_nettype none
module sig_src (
  input  wire logic clk,
  output logic      src,
  output logic      gate,
  output logic      dir
);
  // ********
  // Pin drivers
  // ********
  logic [2:0] p = 3'b100;
  assign {dir, gate, src} = p;
  // Each level is held at least 4 cycles so the synchroniser sees every edge.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) p[0] <= 1'b1;
      repeat (4) @(posedge clk);
      p[0] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic drive(input int k, input logic v);
    @(posedge clk) p[k] <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> verification/test_gated_edge_period_counter.sv
/* Self-checking bench: Wishbone master, DMA sink and pin model.
   Assumes sig_src drives the pins and the checker is bound below. */
`timescale 1ns/1ps
`default_nettype none
module test_gated_edge_period_counter;
  import edge_counter_pkg::*;
  logic        clk, rst_n, we, cyc, stb, ack, err;
  logic        src, gate, dir, valid, acc, e;
  logic [7:0]  adr;
  logic [3:0]  sel, lane0;
  logic [31:0] wdat, rdat, ddat, q;
  int          err_total, tests_run, cyc_n, n, m;
  gated_edge_period_counter dut (
    .SYS_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack), .WB_ERR_O(err), .SOURCE(src),
    .GATE(gate), .DIR_SEL(dir), .DMA_VALID(valid), .DMA_DATA(ddat),
    .DMA_ACCEPT(acc));
  sig_src ss (.clk(clk), .src(src), .gate(gate), .dir(dir));
  // ********
  // Clock, timeout and shared tasks
  // ********
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // The request is held until ack or err is seen, then released.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    sel <= (4'($urandom) & 4'he) | lane0;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    r = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0, q);
    check(q, x);
  endtask
  function automatic ctrl_t cf(input int md, sf, gp, dr, cu, bu);
    return ctrl_t'({bu[0], cu[0], dr[1:0], gp[0], sf[0], 1'b0, md[2:0]});
  endfunction
  task automatic go(input ctrl_t c);
    wb(1'b1, REG_ARM, 32'h2, q);
    wb(1'b1, REG_CTRL, 32'(c), q);
    wb(1'b1, REG_ARM, 32'h1, q);
  endtask
  task automatic take(input logic [31:0] x);
    while (valid !== 1'b1) begin
      @(negedge clk);
    end
    repeat ($urandom_range(4, 1)) @(negedge clk);
    check(32'(valid), 32'h1);
    check(ddat, x);
    @(posedge clk) acc <= 1'b1;
    @(posedge clk) acc <= 1'b0;
    @(negedge clk) check(32'(valid), 32'h0);
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    {rst_n, cyc, stb, we, acc, adr, wdat} = '0;
    sel = 4'hf;
    lane0 = 4'h1;
    void'($urandom(83389));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, 32'(CTRL_RESET));
    wb(1'b0, 8'h14, 32'h0, q);
    check(32'(e), 32'h1);
    for (int d = 0; d < 3; d++) begin
      n = $urandom_range(12, 1);
      go(cf(0, 0, 0, d, 0, 0));
      ss.pulse(n);
      rd(REG_COUNT, (d == 1) ? -n : n);
      rd(REG_COUNT, (d == 1) ? -n : n);
    end
    m = $urandom_range(12, 1);
    ss.drive(2, 1'b0);
    ss.pulse(m);
    rd(REG_COUNT, n - m);
    ss.drive(2, 1'b1);
    go(cf(0, 0, 0, 0, 0, 0));
    rd(REG_COUNT, 32'h0);
    for (int f = 0; f < 2; f++) begin
      go(cf(0, f, 0, 0, 0, 0));
      ss.drive(0, 1'b1);
      rd(REG_COUNT, 32'(f == 0));
      ss.drive(0, 1'b0);
    end
    for (int g = 0; g < 2; g++) begin
      ss.drive(1, g[0]);
      go(cf(0, 0, g, 0, 0, 0));
      n = $urandom_range(12, 1);
      ss.pulse(n);
      ss.drive(1, !g[0]);
      ss.pulse(3);
      rd(REG_COUNT, n);
    end
    // A control write while armed is acknowledged but has no effect.
    wb(1'b1, REG_CTRL, 32'h1, q);
    rd(REG_CTRL, 32'(cf(0, 0, 1, 0, 0, 0)));
    // With byte lane 0 off, a control write after stop is ignored too.
    wb(1'b1, REG_ARM, 32'h2, q);
    lane0 = 4'h0;
    wb(1'b1, REG_CTRL, 32'h1, q);
    lane0 = 4'h1;
    rd(REG_CTRL, 32'(cf(0, 0, 1, 0, 0, 0)));
    for (int c = 0; c < 2; c++) begin
      ss.drive(1, c[0]);
      go(cf(0, 0, c, 0, c, 1));
      n = $urandom_range(12, 1);
      ss.pulse(n);
      ss.drive(1, !c[0]);
      take(n);
      m = $urandom_range(12, 1);
      ss.pulse(m);
      ss.drive(1, c[0]);
      check(32'(valid), 32'h0);
      ss.drive(1, !c[0]);
      take((c == 1) ? n + m : m);
    end
    for (int k = 1; k < 4; k += 2) begin
      ss.drive(1, 1'b1);
      go(cf(k, 0, 0, 0, 0, 0));
      ss.pulse(2);
      ss.drive(1, 1'b0);
      ss.pulse(1);
      ss.drive(1, 1'b1);
      n = $urandom_range(12, 1);
      ss.pulse(n);
      ss.drive(1, 1'b0);
      rd(REG_SAVE, n);
      ss.drive(1, 1'b1);
      ss.pulse(3);
      ss.drive(1, 1'b0);
      rd(REG_SAVE, n);
    end
    for (int g = 0; g < 2; g++) begin
      ss.drive(1, g[0]);
      go(cf(2, 0, g, 0, 0, 0));
      ss.pulse(2);
      ss.drive(1, !g[0]);
      n = $urandom_range(12, 1);
      ss.pulse(n);
      ss.drive(1, g[0]);
      ss.pulse(2);
      ss.drive(1, !g[0]);
      rd(REG_SAVE, n + 2);
      ss.pulse(3);
      ss.drive(1, g[0]);
      ss.drive(1, !g[0]);
      rd(REG_SAVE, n + 2);
    end
    ss.drive(1, 1'b0);
    go(cf(1, 0, 0, 0, 0, 1));
    repeat (2) begin
      ss.drive(1, 1'b1);
      n = $urandom_range(12, 1);
      ss.pulse(n);
      ss.drive(1, 1'b0);
      take(n);
    end
    go(cf(2, 0, 0, 0, 0, 1));
    ss.pulse(4);
    ss.drive(1, 1'b1);
    take(32'h4);
    ss.pulse(3);
    ss.drive(1, 1'b0);
    ss.pulse(5);
    ss.drive(1, 1'b1);
    take(32'h8);
    go(cf(3, 0, 0, 0, 0, 1));
    ss.pulse(6);
    ss.drive(1, 1'b0);
    take(32'h6);
    ss.pulse(2);
    ss.drive(1, 1'b1);
    take(32'h2);
    ss.pulse(1);
    ss.drive(1, 1'b0);
    ss.pulse(1);
    ss.drive(1, 1'b1);
    n = (1 << STAT_ARMED) | (1 << STAT_SAVED) | (1 << STAT_OVERRUN);
    rd(REG_STATUS, n);
    take(32'h1);
    final_report();
  end
endmodule
bind gated_edge_period_counter gated_edge_period_counter_chk #(
  .WIDTH(WIDTH)) chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .WB_ERR_O(WB_ERR_O), .GATE(GATE), .DMA_VALID(DMA_VALID),
  .DMA_DATA(DMA_DATA), .DMA_ACCEPT(DMA_ACCEPT));
`default_nettype wire
